// file: rtl/tcm_pkg.sv
package tcm_pkg;
  // ==========================================
  // register map (word index, byte addr = 4 * index)
  localparam logic [7:0] IDX_CH0_CTRL = 8'h26;  // channel 0 control
  localparam logic [7:0] IDX_CH1_LOW = 8'h2B;   // channel1_value_low_byte
  localparam logic [7:0] IDX_STRIDE = 8'h03;    // control, high, low per channel
  localparam logic [7:0] IDX_HIGH = 8'h01;      // high byte after control
  localparam logic [7:0] IDX_LOW = 8'h02;       // low byte after control
  localparam logic [21:0] ADDR_TOP_ZERO = 22'h000000;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // ==========================================
  // control byte fields
  localparam int F_FLAG = 7;   // channel_event_flag
  localparam int F_MSB = 5;    // buffered_mode_select
  localparam int F_MSA = 4;    // mode_select_a
  localparam int F_ELSB = 3;   // edge_level_select_hi
  localparam int F_ELSA = 2;   // edge_level_select_lo
  localparam int F_TOV = 1;    // toggle_on_wrap
  localparam int F_MAX = 0;    // full_duty_force
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  localparam logic [1:0] MS_CAPTURE = 2'h0;
  localparam int NCH = 4;
  localparam int NPAIR = 2;
  // ==========================================
  // channel function and bus phase
  typedef enum logic [1:0] {
    TCM_PORT = 2'b00,
    TCM_CAPT = 2'b01,
    TCM_CMP = 2'b10,
    TCM_BUF = 2'b11
  } tcm_mode_type;
  typedef enum logic [1:0] {
    TCM_IDLE = 2'b00,
    TCM_WR = 2'b01,
    TCM_RD_WAIT = 2'b10,
    TCM_RD_DONE = 2'b11
  } tcm_bus_type;
endpackage

// file: rtl/tcm_timer_channels.sv
// Overview of operation
// [RULE1] buffered select only on channels 0 and 2
// [RULE2] pair01 buffering disables channel 1, frees pin
// [RULE3] pair23 buffering disables channel 3, frees pin
// [RULE4] mode_select_a picks compare or capture
// [RULE5] edge_level zero: mode_select_a presets level
// [RULE6] reset clears all channel mode bits
// [RULE7] edge_level zero leaves pin to port
// [RULE8] capture edge: rise, fall or both
// [RULE9] compare action toggle, clear or set
// [RULE10] software halts counter before mode change
// [RULE11] pin stable two clocks before capture
// [RULE12] toggle_on_wrap toggles pin on overflow
// [RULE13] overflow beats compare in same cycle
// [RULE14] full_duty_force gives 100 percent duty; the code forces it only while toggle_on_wrap is clear
// [RULE15] full duty change waits next period
// [RULE16] value register holds capture or compare
// [RULE17] capture blocked from high read to low
// [RULE18] compare blocked from high write to low
// [RULE19] event flag on edge or match
// [RULE20] overflow is wrap from modulo to zero
// [RULE21] buffered pair alternates active compare value
//
// The AHB-Lite register port was left to the implementer.
module tcm_timer_channels (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // timer counter, same clock
  input wire logic [15:0] cnt_value,
  input wire logic cnt_step,
  input wire logic cnt_wrap,
  // channel pins
  input wire logic [3:0] channel_pin_sense,
  output logic [3:0] channel_pin_level,
  output logic [3:0] channel_pin_oe,
  // event flags
  output logic [3:0] channel_event_flag
);
  // ==========================================
  // bus front end
  tcm_pkg::tcm_bus_type bus_q;   // data phase state
  logic [7:0] idx_q;             // word index of data phase
  logic ok_q;                    // address was aligned and in range
  logic [7:0] rbyte;             // read mux
  logic [31:0] hrdata_q;
  logic take;                    // address phase accepted
  logic wr_go;                   // write data valid this cycle
  logic rd_go;                   // read side effects fire this cycle

  // reads take one wait state so that a write just before is seen
  assign hreadyout = (bus_q != tcm_pkg::TCM_RD_WAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign take = hsel && hready && (htrans == tcm_pkg::HTRANS_NONSEQ);
  assign wr_go = (bus_q == tcm_pkg::TCM_WR) && ok_q;
  assign rd_go = (bus_q == tcm_pkg::TCM_RD_WAIT) && ok_q;

  // phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q <= tcm_pkg::TCM_IDLE;
      idx_q <= 8'h00;
      ok_q <= 1'b0;
    end else begin
      case (bus_q)
        tcm_pkg::TCM_RD_WAIT: begin
          bus_q <= tcm_pkg::TCM_RD_DONE;
        end
        default: begin
          // idle, write or finished read: ready for a new address
          if (take) begin
            bus_q <= hwrite ? tcm_pkg::TCM_WR : tcm_pkg::TCM_RD_WAIT;
            idx_q <= haddr[9:2];
            ok_q <= (haddr[31:10] == tcm_pkg::ADDR_TOP_ZERO) && (haddr[1:0] == 2'h0)
                    && (hsize == tcm_pkg::HSIZE_WORD);
          end else begin
            bus_q <= tcm_pkg::TCM_IDLE;
          end
        end
      endcase
    end
  end

  // read data captured in the wait cycle; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (bus_q == tcm_pkg::TCM_RD_WAIT) begin
      hrdata_q <= {24'h000000, ok_q ? rbyte : 8'h00};
    end
  end

  // ==========================================
  // per-channel state
  logic [5:0] ctrl_q [tcm_pkg::NCH];   // msb, msa, elsb, elsa, tov, max
  logic [15:0] val_q [tcm_pkg::NCH];   // channel value, no reset
  logic [3:0] flag_q;                  // channel_event_flag
  logic [3:0] arm_q;                   // flag read while set
  logic [3:0] level_q;                 // output level
  logic [3:0] maxact_q;                // full duty in force this period
  logic [3:0] capinh_q;                // capture blocked
  logic [3:0] cmpinh_q;                // compare blocked
  logic [3:0] s1_q, s2_q, s3_q;        // pin synchroniser
  logic [3:0] pin_q;                   // agreed pin level
  logic [15:0] act_q [tcm_pkg::NPAIR]; // active buffered compare value
  logic [1:0] last_q;                  // odd register of pair written last
  logic [7:0] rb [tcm_pkg::NCH];       // per-channel read byte
  logic [3:0] hitv;                    // channel owns the index

  assign channel_event_flag = flag_q;

  // three-stage pin sync; a change counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      pin_q <= 4'h0;
    end else begin
      s1_q <= channel_pin_sense;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int k = 0; k < tcm_pkg::NCH; k++) begin
        if (s2_q[k] == s3_q[k]) begin
          pin_q[k] <= s3_q[k];
        end
      end
    end
  end

  // read mux over channels
  always_comb begin
    rbyte = 8'h00;
    for (int k = 0; k < tcm_pkg::NCH; k++) begin
      if (hitv[k]) begin
        rbyte = rb[k];
      end
    end
  end

  for (genvar i = 0; i < tcm_pkg::NCH; i++) begin : g_ch
    localparam bit ODD = (i % 2) == 1;
    localparam logic [7:0] IC = tcm_pkg::IDX_CH0_CTRL + 8'(i * tcm_pkg::IDX_STRIDE);
    logic hc, hh, hl;                  // index hits: control, high, low
    logic dis;                         // odd channel taken by its pair
    logic bufm;
    logic [1:0] els;
    logic [15:0] cmpv;
    logic match, cap, agree;
    tcm_pkg::tcm_mode_type mode;

    assign hc = idx_q == IC;
    assign hh = idx_q == IC + tcm_pkg::IDX_HIGH;
    assign hl = idx_q == IC + tcm_pkg::IDX_LOW;
    assign hitv[i] = hc || hh || hl;
    assign dis = ODD && ctrl_q[i & 2][tcm_pkg::F_MSB];                    // [RULE2] [RULE3]
    assign bufm = !ODD && ctrl_q[i][tcm_pkg::F_MSB];
    assign els = {ctrl_q[i][tcm_pkg::F_ELSB], ctrl_q[i][tcm_pkg::F_ELSA]};
    assign rb[i] = hc ? {flag_q[i], 1'b0, ctrl_q[i]} : hh ? val_q[i][15:8] : val_q[i][7:0];

    // function decode; odd channel of a buffered pair goes back to port
    always_comb begin
      if (dis || els == tcm_pkg::ELS_OFF) begin
        mode = tcm_pkg::TCM_PORT;                                         // [RULE7]
      end else if (bufm) begin
        mode = tcm_pkg::TCM_BUF;                                          // [RULE1]
      end else if (ctrl_q[i][tcm_pkg::F_MSA]) begin
        mode = tcm_pkg::TCM_CMP;                                          // [RULE4]
      end else begin
        mode = tcm_pkg::TCM_CAPT;
      end
    end

    // buffered channels compare against the pair's active copy
    if (ODD) begin : g_odd
      assign cmpv = val_q[i];
    end else begin : g_even
      assign cmpv = bufm ? act_q[i / 2] : val_q[i];                      // [RULE21]
    end

    assign agree = s2_q[i] == s3_q[i];
    // [RULE8] 01 rise, 10 fall, 11 either
    assign cap = (mode == tcm_pkg::TCM_CAPT) && !capinh_q[i] && agree && (s3_q[i] != pin_q[i])
                 && (s3_q[i] ? els[0] : els[1]);
    assign match = ((mode == tcm_pkg::TCM_CMP) || (mode == tcm_pkg::TCM_BUF)) && cnt_step
                   && !cmpinh_q[i] && (cnt_value == cmpv);

    // control bits: writes ignored while disabled, buffer bit only on 0 and 2
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ctrl_q[i] <= tcm_pkg::CTRL_RESET;                                 // [RULE6]
      end else if (wr_go && hc && !dis) begin
        ctrl_q[i] <= {hwdata[tcm_pkg::F_MSB] && !ODD, hwdata[4:0]};       // [RULE1]
      end
    end

    // event flag: clear needs a prior read with flag set; a new event wins
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        flag_q[i] <= 1'b0;
        arm_q[i] <= 1'b0;
      end else begin
        if (cap || match) begin
          flag_q[i] <= 1'b1;                                              // [RULE19]
        end else if (wr_go && hc && !dis && arm_q[i] && !hwdata[tcm_pkg::F_FLAG]) begin
          flag_q[i] <= 1'b0;
        end
        if (rd_go && hc) begin
          arm_q[i] <= flag_q[i];
        end else if ((wr_go && hc) || cap || match) begin
          arm_q[i] <= 1'b0;
        end
      end
    end

    // value register: captured count or software compare value
    always_ff @(posedge hclk) begin
      if (cap) begin
        val_q[i] <= cnt_value;                                            // [RULE16]
      end else if (wr_go && hh) begin
        val_q[i][15:8] <= hwdata[7:0];
      end else if (wr_go && hl) begin
        val_q[i][7:0] <= hwdata[7:0];
      end
    end

    // byte-access interlocks keep the 16-bit value coherent
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        capinh_q[i] <= 1'b0;
        cmpinh_q[i] <= 1'b0;
      end else begin
        if (rd_go && hh && ctrl_q[i][5:4] == tcm_pkg::MS_CAPTURE) begin
          capinh_q[i] <= 1'b1;                                            // [RULE17]
        end else if (rd_go && hl) begin
          capinh_q[i] <= 1'b0;
        end
        if (wr_go && hh && ctrl_q[i][5:4] != tcm_pkg::MS_CAPTURE) begin
          cmpinh_q[i] <= 1'b1;                                            // [RULE18]
        end else if (wr_go && hl) begin
          cmpinh_q[i] <= 1'b0;
        end
      end
    end

    // output level; overflow toggle takes precedence over a same-cycle match
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        level_q[i] <= 1'b1;
      end else if (mode == tcm_pkg::TCM_PORT) begin
        level_q[i] <= !ctrl_q[i][tcm_pkg::F_MSA];                         // [RULE5]
      end else if (mode != tcm_pkg::TCM_CAPT) begin
        if (cnt_wrap && ctrl_q[i][tcm_pkg::F_TOV]) begin
          level_q[i] <= !level_q[i];                                      // [RULE12] [RULE13] [RULE20]
        end else if (match) begin
          case (els)                                                      // [RULE9]
            tcm_pkg::ELS_TOGGLE: level_q[i] <= !level_q[i];
            tcm_pkg::ELS_CLEAR: level_q[i] <= 1'b0;
            tcm_pkg::ELS_SET: level_q[i] <= 1'b1;
            default: level_q[i] <= level_q[i];
          endcase
        end
      end
    end

    // full duty request is sampled only at the period boundary
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        maxact_q[i] <= 1'b0;
      end else if (cnt_wrap) begin
        maxact_q[i] <= ctrl_q[i][tcm_pkg::F_MAX];                         // [RULE15]
      end
    end

    // pin drive only while the channel owns an output function
    assign channel_pin_oe[i] = (mode == tcm_pkg::TCM_CMP) || (mode == tcm_pkg::TCM_BUF);
    assign channel_pin_level[i] = (channel_pin_oe[i] && maxact_q[i] && !ctrl_q[i][tcm_pkg::F_TOV])
                              ? 1'b1 : level_q[i];                         // [RULE14]

    // pair logic: whichever register was completed last becomes active
    // at the next compare or overflow, even one that lands between its high and low byte writes
    if (!ODD) begin : g_pair
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          last_q[i / 2] <= 1'b0;
          act_q[i / 2] <= 16'h0000;
        end else begin
          if (wr_go && hl) begin
            last_q[i / 2] <= 1'b0;
          end else if (wr_go && g_ch[i + 1].hl) begin
            last_q[i / 2] <= 1'b1;
          end
          if (match || cnt_wrap) begin
            act_q[i / 2] <= last_q[i / 2] ? val_q[i + 1] : val_q[i];        // [RULE21]
          end
        end
      end
    end
  end
endmodule

// file: bench/tcm_timer_channels_props.sv
// ==========
// watcher on the timer channel block ports
module tcm_props (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // counter
  input wire logic [15:0] cnt_value,
  input wire logic cnt_step,
  input wire logic cnt_wrap,
  // pins and flags
  input wire logic [3:0] channel_pin_sense,
  input wire logic [3:0] channel_pin_level,
  input wire logic [3:0] channel_pin_oe,
  input wire logic [3:0] channel_event_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take; // transfer accepted this edge
  logic wr_dp_q; // write data phase
  logic [3:0] pin_last_q; // pin levels one edge ago
  logic [3:0] pin_age_q; // edges since a pin moved, saturating
  assign take = hsel && hready && (htrans == tcm_pkg::HTRANS_NONSEQ);
  // write data phase marker, the cause of every control change and flag clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_dp_q <= 1'b0;
    else if (hready) wr_dp_q <= take && hwrite;
  end
  // age of last pin move; zero after reset so early edges are excused
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_last_q <= 4'h0;
      pin_age_q <= 4'h0;
    end else begin
      pin_last_q <= channel_pin_sense;
      if (channel_pin_sense != pin_last_q) pin_age_q <= 4'h0;
      else if (pin_age_q != 4'hF) pin_age_q <= pin_age_q + 4'h1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
  write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write waited");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read timing");
  rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout)) else $error("read data moved");
  oe_by_write_a: assert property ($changed(channel_pin_oe) |-> $past(wr_dp_q)) else $error("enable moved");
  pin_cause_a: assert property ((channel_pin_oe == $past(channel_pin_oe)) &&
    ((channel_pin_level & channel_pin_oe) != ($past(channel_pin_level) & channel_pin_oe)) |->
    $past(cnt_step) || $past(cnt_step, 2) || $past(cnt_wrap) || $past(cnt_wrap, 2) || $past(wr_dp_q))
    else $error("pin moved without cause");
  flag_cause_a: assert property ((channel_event_flag & ~$past(channel_event_flag)) != 4'h0 |->
    $past(cnt_step) || $past(cnt_step, 2) || (pin_age_q < 4'hA)) else $error("flag set without event");
  flag_clear_a: assert property ((~channel_event_flag & $past(channel_event_flag)) != 4'h0 |->
    $past(wr_dp_q)) else $error("flag cleared without write");
endmodule
bind tcm_timer_channels tcm_props tcm_props_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .cnt_value(cnt_value), .cnt_step(cnt_step), .cnt_wrap(cnt_wrap),
  .channel_pin_sense(channel_pin_sense), .channel_pin_level(channel_pin_level), .channel_pin_oe(channel_pin_oe),
  .channel_event_flag(channel_event_flag));

// file: bench/tcm_pin_model.sv
// ==========
// far side of the channel pins
module tcm_pin_model (
  // block side
  input wire logic [3:0] blk_level,
  input wire logic [3:0] blk_oe,
  // outside source, kept steady by the bench before capture is armed
  input wire logic [3:0] ext_lvl,
  output logic [3:0] pad_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin shows the block's level, a released one the outside source
  assign pad_level = (blk_oe & blk_level) | (~blk_oe & ext_lvl);
endmodule

// file: bench/tb_top.sv
// ==========
// bench for the timer channel block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cnt_step, cnt_wrap;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] cnt_value;
  logic [3:0] pin_i, pin_o, pin_oe, flag, ext_lvl;
  int miscompares, total_checks, cycles;
  assign hready = hreadyout; // single slave
  tcm_timer_channels tcm_timer_channels_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cnt_value(cnt_value), .cnt_step(cnt_step),
    .cnt_wrap(cnt_wrap), .channel_pin_sense(pin_i), .channel_pin_level(pin_o), .channel_pin_oe(pin_oe),
    .channel_event_flag(flag));
  tcm_pin_model tcm_pin_model_i (.blk_level(pin_o), .blk_oe(pin_oe), .ext_lvl(ext_lvl), .pad_level(pin_i));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // watchdog; the whole run needs far fewer cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ==========
  // helpers
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] ix(input int n, input logic [7:0] off);
    return tcm_pkg::IDX_CH0_CTRL + 8'(tcm_pkg::IDX_STRIDE * n) + off;
  endfunction
  // one single transfer; the address phase holds until hready is seen high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'h0};
    htrans <= tcm_pkg::HTRANS_NONSEQ;
    hsize <= tcm_pkg::HSIZE_WORD;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rdv = hrdata;
    @(posedge hclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(rdv, {24'h000000, e});
  endtask
  // one counter advance, optionally the wrap to zero as well
  task automatic step(input logic [15:0] v, input logic w);
    @(posedge hclk);
    cnt_value <= v;
    cnt_step <= 1'b1;
    cnt_wrap <= w;
    @(posedge hclk);
    cnt_step <= 1'b0;
    cnt_wrap <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
  endtask
  // one outside pin move, with the counter value that a capture would take
  task automatic pin(input int n, input logic v, input logic [15:0] c);
    @(posedge hclk);
    ext_lvl[n] <= v;
    cnt_value <= c;
    repeat (8) @(posedge hclk);
    #1;
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    for (int n = 0; n < 4; n++) rd(ix(n, 8'h00), 8'h00);
    chk(pin_oe, 4'h0);
    rd(8'hFF, 8'h00);
    wr(tcm_pkg::IDX_CH1_LOW, 8'hA5);
    rd(tcm_pkg::IDX_CH1_LOW, 8'hA5);
  endtask
  task automatic t_pair();
    for (int e = 0; e < 4; e += 2) begin
      wr(ix(e + 1, 8'h00), 8'h34);
      rd(ix(e + 1, 8'h00), 8'h14);
      chk(pin_oe[e + 1], 1'b1);
      wr(ix(e, 8'h00), 8'h24);
      rd(ix(e, 8'h00), 8'h24);
      chk(pin_oe[e +: 2], 2'h1);
      wr(ix(e + 1, 8'h00), 8'h00);
      wr(ix(e, 8'h00), 8'h00);
      chk(pin_oe[e +: 2], 2'h2);
      wr(ix(e + 1, 8'h00), 8'h00);
      chk(pin_oe[e +: 2], 2'h0);
    end
  endtask
  task automatic t_cmp();
    wr(ix(0, 8'h01), 8'h00);
    wr(ix(0, 8'h02), 8'h05);
    wr(ix(0, 8'h00), 8'h10);
    chk(pin_oe[0], 1'b0);
    wr(ix(0, 8'h00), 8'h1C);
    chk(pin_o[0], 1'b0);
    step(16'h0006, 1'b0);
    chk(pin_o[0], 1'b0);
    step(16'h0005, 1'b0);
    chk({flag[0], pin_o[0]}, 2'h3);
    wr(ix(0, 8'h00), 8'h18);
    step(16'h0005, 1'b0);
    chk(pin_o[0], 1'b0);
    wr(ix(0, 8'h00), 8'h14);
    step(16'h0005, 1'b0);
    chk(pin_o[0], 1'b1);
    wr(ix(0, 8'h01), 8'h00);
    step(16'h0005, 1'b0);
    chk(pin_o[0], 1'b1);
    wr(ix(0, 8'h02), 8'h05);
    step(16'h0005, 1'b0);
    chk(pin_o[0], 1'b0);
    wr(ix(0, 8'h00), 8'h1E);
    step(16'h0005, 1'b0);
    step(16'h0005, 1'b1);
    chk(pin_o[0], 1'b0);
    step(16'h0007, 1'b1);
    chk(pin_o[0], 1'b1);
    wr(ix(0, 8'h00), 8'h19);
    step(16'h0005, 1'b0);
    chk(pin_o[0], 1'b0);
    step(16'h0009, 1'b1);
    step(16'h0005, 1'b0);
    chk(pin_o[0], 1'b1);
    wr(ix(0, 8'h00), 8'h18);
    chk(pin_o[0], 1'b1);
    step(16'h0009, 1'b1);
    chk(pin_o[0], 1'b0);
    // flag clears only after a read that saw it set
    rd(ix(0, 8'h00), 8'h98);
    wr(ix(0, 8'h00), 8'h18);
    chk(flag[0], 1'b0);
  endtask
  // buffered pair 0/1: the active copy moves only at a wrap or a match
  task automatic t_buf();
    wr(ix(0, 8'h00), 8'h00);
    wr(ix(0, 8'h01), 8'h00);
    wr(ix(0, 8'h02), 8'h10);
    wr(ix(1, 8'h01), 8'h00);
    wr(ix(1, 8'h02), 8'h20);
    wr(ix(0, 8'h00), 8'h24);
    step(16'h0000, 1'b1);
    chk(pin_o[0], 1'b1);
    step(16'h0010, 1'b0);
    chk(pin_o[0], 1'b1);
    step(16'h0020, 1'b0);
    chk(pin_o[0], 1'b0);
    wr(ix(0, 8'h02), 8'h10);
    step(16'h0020, 1'b0);
    chk(pin_o[0], 1'b1);
    step(16'h0010, 1'b0);
    chk(pin_o[0], 1'b0);
  endtask
  task automatic t_cap();
    wr(ix(2, 8'h00), 8'h04);
    pin(2, 1'b1, 16'h1234);
    chk({flag[2], pin_oe[2]}, 2'h2);
    rd(ix(2, 8'h01), 8'h12);
    pin(2, 1'b0, 16'h5678);
    pin(2, 1'b1, 16'h5678);
    rd(ix(2, 8'h02), 8'h34);
    pin(2, 1'b0, 16'h5678);
    pin(2, 1'b1, 16'h5678);
    rd(ix(2, 8'h01), 8'h56);
    rd(ix(2, 8'h02), 8'h78);
    wr(ix(2, 8'h00), 8'h08);
    pin(2, 1'b0, 16'h9ABC);
    rd(ix(2, 8'h01), 8'h9A);
    rd(ix(2, 8'h02), 8'hBC);
    pin(2, 1'b1, 16'h1111);
    rd(ix(2, 8'h01), 8'h9A);
    rd(ix(2, 8'h02), 8'hBC);
    // either edge captures
    wr(ix(2, 8'h00), 8'h0C);
    pin(2, 1'b0, 16'h2222);
    rd(ix(2, 8'h01), 8'h22);
    rd(ix(2, 8'h02), 8'h22);
    pin(2, 1'b1, 16'h3333);
    rd(ix(2, 8'h01), 8'h33);
    rd(ix(2, 8'h02), 8'h33);
  endtask
  initial begin
    {hsel, hwrite, cnt_step, cnt_wrap} = 4'h0;
    {haddr, hwdata, htrans, hsize, cnt_value, ext_lvl} = '0;
    {miscompares, total_checks, cycles} = '0;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_pair();
    t_cmp();
    t_buf();
    t_cap();
    end_of_test();
  end
endmodule
